// ---- common/bldc_cfg.svh ----
// Constants for the commutation decoder: register map, field positions and reset values
// Function
// - Fault output low on bad code, no run, over-current, undervoltage or overtemperature.
// - Select input high decodes 60 degree sensor phasing, low decodes 120 degree.
// - Run enable low: tops off, bottoms low, motor coasts, fault active.
// - Floating run enable reads as asserted, so sequencing is on by default.
// - Brake high: all tops off, all bottoms on, windings shorted.
// - Brake overrides enable, direction, current sense and sensor code.
// - Floating brake input reads high, so braking engages by default.
// - Bottoms for braking wait until all three top commands are off.
// - Brake interlock watches internal top commands, not the top pins.
// - Six of eight sensor codes are valid sectors; two flag invalid.
// - Direction change swaps top and bottom of each phase for the code.
// - Over-current ends bottom switch conduction for the rest of the oscillator cycle; top drives stay on.
// - Top drives and fault output are active low.
// - Invalid code without brake: all drives off, fault low.
// - Invalid code with brake: tops off, bottoms on, fault low.
`ifndef BLDC_CFG_SVH
`define BLDC_CFG_SVH

// ==========================================================
// Register map
`define BLDC_ADDR_W        8
`define BLDC_DATA_W        32
`define BLDC_REG_CTRL      8'h00
`define BLDC_REG_STATUS    8'h04
`define BLDC_REG_IRQ_STAT  8'h08
`define BLDC_REG_IRQ_MASK  8'h0C

// ==========================================================
// Control fields and reset values
`define BLDC_CTRL_RUN      0
`define BLDC_CTRL_BRAKE    1
`define BLDC_CTRL_RUN_RST  1'h1
`define BLDC_CTRL_BRK_RST  1'h0

// ==========================================================
// Status fields
`define BLDC_ST_PINS_LSB   0
`define BLDC_ST_PINS_MSB   14
`define BLDC_ST_SEC_LSB    15
`define BLDC_ST_SEC_MSB    17
`define BLDC_ST_VALID      18
`define BLDC_ST_TOP_LSB    19
`define BLDC_ST_TOP_MSB    21
`define BLDC_ST_BOT_LSB    22
`define BLDC_ST_BOT_MSB    24
`define BLDC_ST_FAULT      25
`define BLDC_ST_ILIM       26
`define BLDC_ST_MODE_LSB   27
`define BLDC_ST_MODE_MSB   28

// ==========================================================
// Interrupt events
`define BLDC_EV_W          6
`define BLDC_EV_INVALID    0
`define BLDC_EV_ILIM       1
`define BLDC_EV_FAULT      2
`define BLDC_EV_BRAKE      3
`define BLDC_EV_DIR        4
`define BLDC_EV_SECTOR     5
`define BLDC_IRQ_MASK_RST  6'h00

// ==========================================================
// Synchroniser and phase bit order
`define BLDC_SYNC_W        15
`define BLDC_SYNC_RST      15'h060F
`define BLDC_PH_A          2
`define BLDC_PH_B          1
`define BLDC_PH_C          0
`define BLDC_PH_NONE       3'h0
`define BLDC_PH_ALL        3'h7

`endif

// ---- common/bldc_pkg.sv ----
// Types shared by the commutation decoder modules
`include "bldc_cfg.svh"

package bldc_pkg;

    // ==========================================================
    // Brake interlock mode, Gray along run -> wait -> brake
    typedef enum logic [1:0] {
        BLDC_RUN      = 2'h0,
        BLDC_TOP_WAIT = 2'h1,
        BLDC_BRAKING  = 2'h3
    } bldc_mode_e;

    // ==========================================================
    // Synchronised inputs, reset value in BLDC_SYNC_RST
    typedef struct packed {
        logic       hall_one;
        logic       hall_two;
        logic       hall_three;
        logic       dir;
        logic       run;
        logic       brake;
        logic       sel60;
        logic       ilim;
        logic       osc;
        logic       uvlo;
        logic       tsd;
        logic [2:0] top_pin;
        logic       fault_pin;
    } bldc_pins_s;

    typedef struct packed {
        logic [`BLDC_SYNC_W-1:0] s1;
        logic [`BLDC_SYNC_W-1:0] s2;
        logic [`BLDC_SYNC_W-1:0] s3;
        logic [`BLDC_SYNC_W-1:0] q;
    } bldc_sync_s;

    typedef struct packed {
        logic       valid;
        logic [2:0] sector;
        logic [2:0] top;
        logic [2:0] bot;
    } bldc_dec_s;

    // Switch-on commands, one per bridge transistor
    typedef struct packed {
        logic phase_a_high_side_drive;
        logic phase_b_high_side_drive;
        logic phase_c_high_side_drive;
        logic phase_a_low_side_drive;
        logic phase_b_low_side_drive;
        logic phase_c_low_side_drive;
    } bldc_drive_s;

    typedef struct packed {
        bldc_mode_e              mode;
        logic [2:0]              top_cmd;
        logic [2:0]              bot_cmd;
        logic                    fault;
        logic                    ilim_latch;
        logic                    osc_prev;
        logic                    dir_prev;
        logic                    valid_prev;
        logic                    fault_prev;
        logic [2:0]              sector_prev;
        logic                    run_sw;
        logic                    brake_sw;
        logic [`BLDC_EV_W-1:0]   irq_stat;
        logic [`BLDC_EV_W-1:0]   irq_mask;
        logic [`BLDC_DATA_W-1:0] rdata;
    } bldc_state_s;

endpackage

// ---- hw/bldc_sync.sv ----
// Three-stage input synchroniser with second/third stage agreement
`timescale 1ns/100ps
`include "bldc_cfg.svh"

module bldc_sync (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    input  wire logic [`BLDC_SYNC_W-1:0] din,
    output logic      [`BLDC_SYNC_W-1:0] dout
);

    bldc_pkg::bldc_sync_s    st_ff;
    bldc_pkg::bldc_sync_s    nxt_st;
    logic [`BLDC_SYNC_W-1:0] agree;

    always_comb begin
        nxt_st = st_ff;
        agree  = ~(st_ff.s2 ^ st_ff.s3);
        if (ce) begin
            nxt_st.s1 = din;
            nxt_st.s2 = st_ff.s1;
            nxt_st.s3 = st_ff.s2;
            nxt_st.q  = (agree & st_ff.s3) | (~agree & st_ff.q);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= {4{`BLDC_SYNC_RST}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.q;

endmodule

// ---- hw/bldc_sector_decode.sv ----
// Hall code to sector and phase drive table
`timescale 1ns/100ps
`include "bldc_cfg.svh"

module bldc_sector_decode (
    input  wire logic [2:0]      hall_code,
    input  wire logic            sel60,
    input  wire logic            dir,
    output bldc_pkg::bldc_dec_s  dec
);

    logic [2:0] sec;
    logic       ok;
    logic [2:0] fwd_top;
    logic [2:0] fwd_bot;

    always_comb begin
        sec = 3'h0;
        ok  = 1'h1;
        if (sel60) begin
            case (hall_code)
                3'h4:    sec = 3'h0;
                3'h6:    sec = 3'h1;
                3'h7:    sec = 3'h2;
                3'h3:    sec = 3'h3;
                3'h1:    sec = 3'h4;
                3'h0:    sec = 3'h5;
                default: ok  = 1'h0;
            endcase
        end else begin
            case (hall_code)
                3'h4:    sec = 3'h0;
                3'h6:    sec = 3'h1;
                3'h2:    sec = 3'h2;
                3'h3:    sec = 3'h3;
                3'h1:    sec = 3'h4;
                3'h5:    sec = 3'h5;
                default: ok  = 1'h0;
            endcase
        end
        // Forward table, bit order A B C
        case (sec)
            3'h0:    begin fwd_top = 3'h4; fwd_bot = 3'h1; end
            3'h1:    begin fwd_top = 3'h2; fwd_bot = 3'h1; end
            3'h2:    begin fwd_top = 3'h2; fwd_bot = 3'h4; end
            3'h3:    begin fwd_top = 3'h1; fwd_bot = 3'h4; end
            3'h4:    begin fwd_top = 3'h1; fwd_bot = 3'h2; end
            default: begin fwd_top = 3'h4; fwd_bot = 3'h2; end
        endcase
        dec = '0;
        if (ok) begin
            dec.valid  = 1'h1;
            dec.sector = sec;
            dec.top    = dir ? fwd_top : fwd_bot;
            dec.bot    = dir ? fwd_bot : fwd_top;
        end
    end

endmodule

// ---- hw/bldc_commutation_decoder.sv ----
// Rotor position decoder, brake interlock, current limit and register slave
`timescale 1ns/100ps
`include "bldc_cfg.svh"

module bldc_commutation_decoder (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    input  wire logic                    hall_input_one,
    input  wire logic                    hall_input_two,
    input  wire logic                    hall_input_three,
    input  wire logic                    dir_in,
    input  wire logic                    run_enable_in,
    input  wire logic                    brake_in,
    input  wire logic                    sel60_in,
    input  wire logic                    ilim_in,
    input  wire logic                    osc_cycle_in,
    input  wire logic                    uvlo_in,
    input  wire logic                    tsd_in,
    output logic                         phase_a_high_side_drive_o,
    output logic                         phase_a_high_side_drive_oe,
    input  wire logic                    phase_a_high_side_drive_i,
    output logic                         phase_b_high_side_drive_o,
    output logic                         phase_b_high_side_drive_oe,
    input  wire logic                    phase_b_high_side_drive_i,
    output logic                         phase_c_high_side_drive_o,
    output logic                         phase_c_high_side_drive_oe,
    input  wire logic                    phase_c_high_side_drive_i,
    output logic                         phase_a_low_side_drive,
    output logic                         phase_b_low_side_drive,
    output logic                         phase_c_low_side_drive,
    output logic                         fault_n_o,
    output logic                         fault_n_oe,
    input  wire logic                    fault_n_i,
    input  wire logic [`BLDC_ADDR_W-1:0] reg_addr,
    input  wire logic [`BLDC_DATA_W-1:0] reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [`BLDC_DATA_W-1:0] reg_rdata,
    output logic                         irq
);

    // ==========================================================
    // Signals
    bldc_pkg::bldc_state_s   st_ff;
    bldc_pkg::bldc_state_s   nxt_st;
    bldc_pkg::bldc_pins_s    pins_raw;
    bldc_pkg::bldc_pins_s    pins;
    bldc_pkg::bldc_dec_s     dec;
    bldc_pkg::bldc_drive_s   drv;

    logic [`BLDC_EV_W-1:0]   ev;
    logic [`BLDC_EV_W-1:0]   w1c;
    logic [`BLDC_DATA_W-1:0] status_word;
    logic                    brake_req;
    logic                    run_ok;
    logic                    osc_rise;
    logic                    fault_now;
    logic                    stop_now;

    // ==========================================================
    // Input synchronisation
    always_comb begin
        pins_raw.hall_one   = hall_input_one;
        pins_raw.hall_two   = hall_input_two;
        pins_raw.hall_three = hall_input_three;
        pins_raw.dir        = dir_in;
        pins_raw.run        = run_enable_in;
        pins_raw.brake      = brake_in;
        pins_raw.sel60      = sel60_in;
        pins_raw.ilim       = ilim_in;
        pins_raw.osc        = osc_cycle_in;
        pins_raw.uvlo       = uvlo_in;
        pins_raw.tsd        = tsd_in;
        // Readback pins feed STATUS only
        pins_raw.top_pin    = {phase_a_high_side_drive_i, phase_b_high_side_drive_i, phase_c_high_side_drive_i};
        pins_raw.fault_pin  = fault_n_i;
    end

    bldc_sync u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .din   (pins_raw),
        .dout  (pins)
    );

    // Live decode of the synchronised code
    bldc_sector_decode u_decode (
        .hall_code (  {pins.hall_one, pins.hall_two, pins.hall_three}),
        .sel60     (pins.sel60),
        .dir       (pins.dir),
        .dec       (dec)
    );

    // ==========================================================
    // Status word
    always_comb begin
        status_word = '0;
        status_word[`BLDC_ST_PINS_MSB:`BLDC_ST_PINS_LSB] = pins;
        status_word[`BLDC_ST_SEC_MSB:`BLDC_ST_SEC_LSB]   = dec.sector;
        status_word[`BLDC_ST_VALID]                      = dec.valid;
        status_word[`BLDC_ST_TOP_MSB:`BLDC_ST_TOP_LSB]   = st_ff.top_cmd;
        status_word[`BLDC_ST_BOT_MSB:`BLDC_ST_BOT_LSB]   = st_ff.bot_cmd;
        status_word[`BLDC_ST_FAULT]                      = st_ff.fault;
        status_word[`BLDC_ST_ILIM]                       = st_ff.ilim_latch;
        status_word[`BLDC_ST_MODE_MSB:`BLDC_ST_MODE_LSB] = st_ff.mode;
    end

    // ==========================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        ev     = '0;
        w1c    = '0;

        brake_req = pins.brake | st_ff.brake_sw;
        run_ok    = pins.run & st_ff.run_sw;
        osc_rise  = pins.osc & ~st_ff.osc_prev;
        stop_now  = ~run_ok | pins.uvlo | pins.tsd;
        fault_now = ~dec.valid | ~run_ok | pins.ilim | pins.uvlo | pins.tsd;

        if (ce) begin
            nxt_st.osc_prev = pins.osc;

            if (osc_rise) begin
                nxt_st.ilim_latch = 1'h0;
            end
            if (pins.ilim) begin
                nxt_st.ilim_latch = 1'h1;
            end

            case (st_ff.mode)
                bldc_pkg::BLDC_RUN: begin
                    if (brake_req) begin
                        nxt_st.mode = bldc_pkg::BLDC_TOP_WAIT;
                    end
                end
                bldc_pkg::BLDC_TOP_WAIT: begin
                    if (!brake_req) begin
                        nxt_st.mode = bldc_pkg::BLDC_RUN;
                    end else if (st_ff.top_cmd == `BLDC_PH_NONE) begin
                        nxt_st.mode = bldc_pkg::BLDC_BRAKING;
                    end
                end
                bldc_pkg::BLDC_BRAKING: begin
                    if (!brake_req) begin
                        nxt_st.mode = bldc_pkg::BLDC_RUN;
                    end
                end
                default: begin
                    nxt_st.mode = bldc_pkg::BLDC_RUN;
                end
            endcase

            if (brake_req) begin
                nxt_st.top_cmd = `BLDC_PH_NONE;
                // bottoms only once in braking mode
                nxt_st.bot_cmd = (nxt_st.mode == bldc_pkg::BLDC_BRAKING) ? `BLDC_PH_ALL : `BLDC_PH_NONE;
            end else if (!dec.valid) begin
                nxt_st.top_cmd = `BLDC_PH_NONE;
                nxt_st.bot_cmd = `BLDC_PH_NONE;
            end else if (stop_now) begin
                nxt_st.top_cmd = `BLDC_PH_NONE;
                nxt_st.bot_cmd = `BLDC_PH_NONE;
            end else begin
                // Top held off on a phase whose bottom still conducts
                nxt_st.top_cmd = dec.top & ~st_ff.bot_cmd;
                nxt_st.bot_cmd = nxt_st.ilim_latch ? `BLDC_PH_NONE : dec.bot;
            end

            nxt_st.fault       = fault_now;
            // History for edge events
            nxt_st.dir_prev    = pins.dir;
            nxt_st.valid_prev  = dec.valid;
            nxt_st.fault_prev  = st_ff.fault;
            nxt_st.sector_prev = dec.sector;

            // Events
            ev[`BLDC_EV_INVALID] = st_ff.valid_prev & ~dec.valid;
            ev[`BLDC_EV_ILIM]    = pins.ilim & ~st_ff.ilim_latch;
            ev[`BLDC_EV_FAULT]   = st_ff.fault & ~st_ff.fault_prev;
            ev[`BLDC_EV_BRAKE]   = (nxt_st.mode == bldc_pkg::BLDC_BRAKING) & (st_ff.mode != bldc_pkg::BLDC_BRAKING);
            ev[`BLDC_EV_DIR]     = pins.dir ^ st_ff.dir_prev;
            ev[`BLDC_EV_SECTOR]  = dec.valid & st_ff.valid_prev & (dec.sector != st_ff.sector_prev);

            // Register writes
            if (reg_wr) begin
                case (reg_addr)
                    `BLDC_REG_CTRL: begin
                        nxt_st.run_sw   = reg_wdata[`BLDC_CTRL_RUN];
                        nxt_st.brake_sw = reg_wdata[`BLDC_CTRL_BRAKE];
                    end
                    `BLDC_REG_IRQ_STAT: begin
                        w1c = reg_wdata[`BLDC_EV_W-1:0];
                    end
                    `BLDC_REG_IRQ_MASK: begin
                        nxt_st.irq_mask = reg_wdata[`BLDC_EV_W-1:0];
                    end
                    default: begin
                    end
                endcase
            end

            // New event wins over a clear in the same cycle
            nxt_st.irq_stat = (st_ff.irq_stat & ~w1c) | ev;

            // Register reads, data valid for one cycle only
            nxt_st.rdata = '0;
            if (reg_rd) begin
                case (reg_addr)
                    `BLDC_REG_CTRL: begin
                        nxt_st.rdata[`BLDC_CTRL_RUN]   = st_ff.run_sw;
                        nxt_st.rdata[`BLDC_CTRL_BRAKE] = st_ff.brake_sw;
                    end
                    `BLDC_REG_STATUS: begin
                        nxt_st.rdata = status_word;
                    end
                    `BLDC_REG_IRQ_STAT: begin
                        nxt_st.rdata[`BLDC_EV_W-1:0] = st_ff.irq_stat;
                    end
                    `BLDC_REG_IRQ_MASK: begin
                        nxt_st.rdata[`BLDC_EV_W-1:0] = st_ff.irq_mask;
                    end
                    default: begin
                        nxt_st.rdata = '0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff.mode        <= bldc_pkg::BLDC_RUN;
            st_ff.top_cmd     <= `BLDC_PH_NONE;
            st_ff.bot_cmd     <= `BLDC_PH_NONE;
            st_ff.fault       <= 1'h1;
            st_ff.ilim_latch  <= 1'h0;
            st_ff.osc_prev    <= 1'h0;
            st_ff.dir_prev    <= 1'h0;
            st_ff.valid_prev  <= 1'h0;
            st_ff.fault_prev  <= 1'h1;
            st_ff.sector_prev <= 3'h0;

            st_ff.run_sw      <= `BLDC_CTRL_RUN_RST;
            st_ff.brake_sw    <= `BLDC_CTRL_BRK_RST;
            st_ff.irq_stat    <= '0;
            st_ff.irq_mask    <= `BLDC_IRQ_MASK_RST;
            st_ff.rdata       <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Outputs
    // Command bits fan out to the six switches
    always_comb begin
        drv.phase_a_high_side_drive = st_ff.top_cmd[`BLDC_PH_A];
        drv.phase_b_high_side_drive = st_ff.top_cmd[`BLDC_PH_B];
        drv.phase_c_high_side_drive = st_ff.top_cmd[`BLDC_PH_C];
        drv.phase_a_low_side_drive  = st_ff.bot_cmd[`BLDC_PH_A];
        drv.phase_b_low_side_drive  = st_ff.bot_cmd[`BLDC_PH_B];
        drv.phase_c_low_side_drive  = st_ff.bot_cmd[`BLDC_PH_C];
    end

    assign phase_a_high_side_drive_o  = 1'h0;
    assign phase_b_high_side_drive_o  = 1'h0;
    assign phase_c_high_side_drive_o  = 1'h0;
    assign phase_a_high_side_drive_oe = drv.phase_a_high_side_drive;
    assign phase_b_high_side_drive_oe = drv.phase_b_high_side_drive;
    assign phase_c_high_side_drive_oe = drv.phase_c_high_side_drive;
    assign phase_a_low_side_drive     = drv.phase_a_low_side_drive;
    assign phase_b_low_side_drive     = drv.phase_b_low_side_drive;
    assign phase_c_low_side_drive     = drv.phase_c_low_side_drive;

    assign fault_n_o                  = 1'h0;
    assign fault_n_oe                 = st_ff.fault;

    // Read data and level interrupt
    assign reg_rdata                  = st_ff.rdata;
    assign irq                        = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule

// ---- dv/bldc_hall_model.sv ----
// Hall sensor model: rotor sector to sensor code, with a broken-wire option
`timescale 1ns/100ps

module bldc_hall_model (
    input  wire logic [2:0] sector,
    input  wire logic       sel60,
    input  wire logic       broken,
    output logic      [2:0] code
);
    localparam logic [17:0] CODES_60  = 18'h017F4;
    localparam logic [17:0] CODES_120 = 18'h296B4;

    // ==========================================================
    // Sensor code
    always_comb begin
        if (broken)
            code = sel60 ? (sector[0] ? 3'h5 : 3'h2) : (sector[0] ? 3'h7 : 3'h0);
        else
            code = sel60 ? CODES_60[3*sector +: 3] : CODES_120[3*sector +: 3];
    end
endmodule

// ---- dv/bldc_commutation_decoder_chk.sv ----
// Port assertions for the commutation decoder
`timescale 1ns/100ps

module bldc_commutation_decoder_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hall_input_one,
    input wire logic hall_input_two,
    input wire logic hall_input_three,
    input wire logic run_enable_in,
    input wire logic brake_in,
    input wire logic sel60_in,
    input wire logic ilim_in,
    input wire logic uvlo_in,
    input wire logic tsd_in,
    input wire logic phase_a_high_side_drive_oe,
    input wire logic phase_b_high_side_drive_oe,
    input wire logic phase_c_high_side_drive_oe,
    input wire logic phase_a_low_side_drive,
    input wire logic phase_b_low_side_drive,
    input wire logic phase_c_low_side_drive,
    input wire logic fault_n_oe
);
    wire logic [2:0] top  = {phase_a_high_side_drive_oe, phase_b_high_side_drive_oe, phase_c_high_side_drive_oe};
    wire logic [2:0] bot  = {phase_a_low_side_drive, phase_b_low_side_drive, phase_c_low_side_drive};
    wire logic [2:0] code = {hall_input_one, hall_input_two, hall_input_three};
    wire logic       all_bot = &bot;
    wire logic       bad  = sel60_in ? (code == 3'h2 || code == 3'h5) : (code == 3'h0 || code == 3'h7);

    // ==========================================================
    // Drive checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_no_shoot: assert property ((top & bot) == 3'h0)
        else $error("shoot-through");
    chk_brake_wait: assert property ($rose(all_bot) |-> $past(top) == 3'h0)
        else $error("bottoms before tops off");
    chk_brake_short: assert property (brake_in [*8] |-> all_bot && top == 3'h0)
        else $error("no brake");
    chk_run_coast: assert property ((!run_enable_in && !brake_in) [*8] |-> {top, bot} == 6'h0 && fault_n_oe)
        else $error("no coast");
    chk_fault_supply: assert property ((uvlo_in || tsd_in) [*8] |-> fault_n_oe)
        else $error("no fault");
    chk_ilim_cut: assert property ((ilim_in && !brake_in) [*8] |-> bot == 3'h0 && fault_n_oe)
        else $error("no limit");
    chk_bad_off: assert property ((bad && !brake_in) [*8] |-> {top, bot} == 6'h0 && fault_n_oe)
        else $error("bad code driven");
    chk_bad_brake: assert property ((bad && brake_in) [*8] |-> all_bot && fault_n_oe)
        else $error("bad code no brake");
endmodule

bind bldc_commutation_decoder bldc_commutation_decoder_chk chk_u (.*);

// ---- dv/test_bldc_commutation_decoder.sv ----
// Self-checking bench for the commutation decoder
`timescale 1ns/100ps
`include "bldc_cfg.svh"
`define CMP(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; $display("wrong value at %0t: %h", $time, a); end end

module test_bldc_commutation_decoder;
    localparam logic [17:0] TOP_FWD = 18'h21294;
    localparam logic [17:0] BOT_FWD = 18'h12909;
    logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, dir_in = 1'b1, run_enable_in = 1'b1, brake_in = 1'b1;
    logic        sel60_in = 1'b1, ilim_in = 1'b0, osc_cycle_in = 1'b0, uvlo_in = 1'b0, tsd_in = 1'b0;
    logic        broken = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, look = 1'b0;
    logic        hall_input_one, hall_input_two, hall_input_three, irq, fault_n_o, fault_n_oe;
    logic        phase_a_low_side_drive, phase_b_low_side_drive, phase_c_low_side_drive;
    logic        phase_a_high_side_drive_o, phase_b_high_side_drive_o, phase_c_high_side_drive_o;
    logic        phase_a_high_side_drive_oe, phase_b_high_side_drive_oe, phase_c_high_side_drive_oe;
    logic [2:0]  sector = 3'h0, t, b;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rs = 32'h73CEEFDD, m, e;
    logic [31:0] q[$];
    int          n_errors = 0, check_count = 0;
    wire logic   phase_a_high_side_drive_i = !phase_a_high_side_drive_oe;
    wire logic   phase_b_high_side_drive_i = !phase_b_high_side_drive_oe;
    wire logic   phase_c_high_side_drive_i = !phase_c_high_side_drive_oe;
    wire logic   fault_n_i = !fault_n_oe;
    wire logic [11:0] drv = {phase_a_high_side_drive_o, phase_b_high_side_drive_o, phase_c_high_side_drive_o,
                            fault_n_o, irq, fault_n_oe, phase_a_high_side_drive_oe, phase_b_high_side_drive_oe,
                            phase_c_high_side_drive_oe, phase_a_low_side_drive, phase_b_low_side_drive,
                            phase_c_low_side_drive};

    bldc_commutation_decoder dut_u (.*);
    bldc_hall_model hall_u (.sector(sector), .sel60(sel60_in), .broken(broken),
                            .code({hall_input_one, hall_input_two, hall_input_three}));

    always #20 clk = ~clk;

    // ==========================================================
    // Result monitor
    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d || look) begin
            e = q.size() ? q.pop_front() : 32'hFFFFFFFF;
            `CMP(rd_d ? reg_rdata : {20'h0, drv}, e)
        end
    end

    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Let inputs settle, then note the expected drive word
    task automatic see(input logic [7:0] v);
        step(10);
        q.push_back({24'h0, v});
        look <= 1'b1;
        step(1);
        look <= 1'b0;
        step(1);
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        if (!w) q.push_back(d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        step(1);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        step(1);
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    initial begin
        step(5);
        rst_n <= 1'b1;
        brake_in <= 1'b0;
        step(2);
        bus(1'b0, 8'h04, 32'h1BC0060F);
        bus(1'b0, 8'h10, 32'h0);
        m = xs();
        bus(1'b1, 8'h0C, m);
        bus(1'b0, 8'h0C, {26'h0, m[5:0]});
        bus(1'b1, 8'h0C, 32'h0);
        for (int s = 0; s < 2; s++)
            for (int d = 0; d < 2; d++)
                for (int k = 0; k < 6; k++) begin
                    sel60_in <= s[0];
                    dir_in <= d[0];
                    sector <= 3'(k);
                    t = TOP_FWD[3*k +: 3];
                    b = BOT_FWD[3*k +: 3];
                    see(d ? {2'b00, t, b} : {2'b00, b, t});
                end
        broken <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            sel60_in <= s[0];
            sector <= {2'b00, s[1]};
            brake_in <= s[1];
            see({2'b01, 3'h0, {3{s[1]}}});
        end
        broken <= 1'b0;
        brake_in <= 1'b0;
        sector <= 3'h0;
        dir_in <= 1'b1;
        run_enable_in <= 1'b0;
        see(8'h40);
        brake_in <= 1'b1;
        see(8'h47);
        run_enable_in <= 1'b1;
        see(8'h07);
        brake_in <= 1'b0;
        step(10);
        bus(1'b1, 8'h08, 32'h3F);
        bus(1'b1, 8'h0C, 32'h4);
        uvlo_in <= 1'b1;
        see(8'hC0);
        bus(1'b0, 8'h08, 32'h4);
        bus(1'b1, 8'h08, 32'h4);
        bus(1'b0, 8'h08, 32'h0);
        tsd_in <= 1'b1;
        uvlo_in <= 1'b0;
        see(8'h40);
        bus(1'b1, 8'h0C, 32'h0);
        tsd_in <= 1'b0;
        ilim_in <= 1'b1;
        see(8'h60);
        ilim_in <= 1'b0;
        see(8'h20);
        osc_cycle_in <= 1'b1;
        see(8'h21);
        if (q.size() != 0) n_errors++;
        print_verdict();
    end
endmodule
